// ### bench/dvp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "dvp_consts.svh"
// ----
// Memory controller: mode 0 ready, 1 every other cycle, 2 stalled
// ----
module dvp_mem_model (
  input  wire logic                   clock_in,
  input  wire logic                   rst_n_in,
  input  wire logic [1:0]             mode_in,
  input  wire logic                   spray_in,
  input  wire logic [`DVP_ADDR_W-1:0] addr_in,
  input  wire logic                   addr_valid_in,
  input  wire logic                   wr_in,
  input  wire logic [`DVP_DATA_W-1:0] wdata_in,
  output logic                        addr_rdy_out,
  output logic [`DVP_DATA_W-1:0]      rdata_out,
  output logic                        rdata_valid_out
);
  logic [`DVP_ADDR_W-1:0] log_a[$];
  logic [`DVP_DATA_W-1:0] log_d[$];
  logic [`DVP_ADDR_W-1:0] rd_q[$];
  logic                   ph_q = 1'h0;
  initial begin
    addr_rdy_out = 1'h0;
    rdata_out = '0;
    rdata_valid_out = 1'h0;
  end
  always @(posedge clock_in) begin
    ph_q <= ~ph_q;
    addr_rdy_out <= rst_n_in && (mode_in == 2'h0 || (mode_in == 2'h1 && ph_q));
    if (rst_n_in && addr_valid_in && addr_rdy_out) begin
      if (wr_in)
        log_d.push_back(wdata_in);
      if (wr_in)
        log_a.push_back(addr_in);
      else
        rd_q.push_back(addr_in);
    end
    // Unrequested words go out only when a scenario asks for them
    rdata_valid_out <= rst_n_in && (spray_in || rd_q.size() != 0);
    // Idle data toggles so a stale word never looks valid
    rdata_out <= (rd_q.size() != 0) ? {4{8'h00, rd_q.pop_front()}} : ~rdata_out;
    if (!rst_n_in)
      rd_q.delete();
  end
endmodule
`default_nettype wire

// ### bench/dvp_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "dvp_consts.svh"
module dvp_chk (
  input wire logic                   clock_in,
  input wire logic                   rst_n_in,
  input wire logic                   clk_en_in,
  input wire dvp_pkg::dvp_pixel_t    pixout_out,
  input wire logic                   pixout_valid_out,
  input wire logic                   pixout_rdy_in,
  input wire logic [`DVP_ADDR_W-1:0] mem_addr_out,
  input wire logic                   mem_addr_valid_out,
  input wire logic                   mem_wr_out,
  input wire logic [`DVP_DATA_W-1:0] mem_wdata_out,
  input wire logic                   mem_addr_rdy_in,
  input wire logic                   mem_rdata_valid_in,
  input wire logic                   input_overflow_error_out,
  input wire logic                   output_overflow_error_out
);
  logic        acc;
  logic        take;
  logic [6:0]  beat_q;
  logic [15:0] x_q;
  assign acc = mem_addr_valid_out && mem_addr_rdy_in && clk_en_in;
  assign take = pixout_valid_out && pixout_rdy_in && clk_en_in;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in)
      beat_q <= 7'h0;
    else if (acc)
      beat_q <= (beat_q == 7'(`DVP_BURST - 1)) ? 7'h0 : beat_q + 7'h1;
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in)
      x_q <= 16'h0;
    else if (take)
      x_q <= (x_q == 16'(`DVP_LINE_WIDTH - 1)) ? 16'h0 : x_q + 16'h1;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_req_hold_stall: assert property (
    mem_addr_valid_out && !mem_addr_rdy_in |=> mem_addr_valid_out && $stable(mem_addr_out)
      && $stable(mem_wdata_out) && $stable(mem_wr_out)) else $error("request moved in stall");
  a_addr_sequential: assert property (
    acc && beat_q != 7'(`DVP_BURST - 1) |=> mem_addr_valid_out && mem_wr_out == $past(mem_wr_out)
      && mem_addr_out == $past(mem_addr_out) + 24'h1) else $error("burst address skipped");
  a_gap_after_burst: assert property (
    acc && beat_q == 7'(`DVP_BURST - 1) |=> !mem_addr_valid_out) else $error("no gap after burst");
  a_burst_length: assert property (
    $fell(mem_addr_valid_out) |-> beat_q == 7'h0) else $error("burst ended early");
  a_pixel_hold: assert property (
    pixout_valid_out && !pixout_rdy_in |=> pixout_valid_out && $stable(pixout_out))
    else $error("pixel changed while stalled");
  a_frame_first: assert property (
    pixout_valid_out && pixout_out.frame_sync |-> pixout_out.line_sync && x_q == 16'h0)
    else $error("frame sync misplaced");
  a_line_start: assert property (
    pixout_valid_out |-> pixout_out.line_sync == (x_q == 16'h0)) else $error("line sync misplaced");
  a_in_ovf_sticky: assert property (
    input_overflow_error_out |=> input_overflow_error_out) else $error("input flag dropped");
  a_out_ovf_cause: assert property (
    $rose(output_overflow_error_out) |-> $past(mem_rdata_valid_in)) else $error("output flag unprompted");
endmodule
bind dvp_top dvp_chk u_chk (.clock_in, .rst_n_in, .clk_en_in, .pixout_out, .pixout_valid_out,
  .pixout_rdy_in, .mem_addr_out, .mem_addr_valid_out, .mem_wr_out, .mem_wdata_out,
  .mem_addr_rdy_in, .mem_rdata_valid_in, .input_overflow_error_out, .output_overflow_error_out);
`default_nettype wire

// ### bench/tb_deinterlacer_video_ports.sv
`timescale 1ns/1ps
`default_nettype none
`include "dvp_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_deinterlacer_video_ports;
  logic                   clk = 1'h0, pclk = 1'h0, rst_n = 1'h0, prdy = 1'h0, spray = 1'h0;
  logic                   pv = 1'h0, pvs = 1'h0, pf = 1'h0;
  logic [23:0]            prgb = 24'h0;
  logic [1:0]             mm = 2'h2;
  dvp_pkg::dvp_pixel_t    pixo;
  logic                   pixo_v, av, wr, ardy, rdv, iovf, oovf;
  logic [`DVP_ADDR_W-1:0] addr;
  logic [`DVP_DATA_W-1:0] wdata, rdata;
  int                     failures = 0, num_checks = 0;
  always #4 clk = ~clk;
  initial begin
    #3;
    forever #40 pclk = ~pclk;
  end
  always @(posedge clk) prdy <= ~prdy;
  dvp_top DUT (.clock_in(clk), .rst_n_in(rst_n), .clk_en_in(1'h1), .pix_clk_in(pclk),
    .pix_val_in(pv), .pix_vsync_in(pvs), .pix_field_in(pf), .pix_rgb_in(prgb),
    .pixout_out(pixo), .pixout_valid_out(pixo_v), .pixout_rdy_in(prdy), .mem_addr_out(addr),
    .mem_addr_valid_out(av), .mem_wr_out(wr), .mem_wdata_out(wdata), .mem_addr_rdy_in(ardy),
    .mem_rdata_in(rdata), .mem_rdata_valid_in(rdv), .input_overflow_error_out(iovf),
    .output_overflow_error_out(oovf));
  dvp_mem_model mem (.clock_in(clk), .rst_n_in(rst_n), .mode_in(mm), .spray_in(spray),
    .addr_in(addr), .addr_valid_in(av), .wr_in(wr), .wdata_in(wdata), .addr_rdy_out(ardy),
    .rdata_out(rdata), .rdata_valid_out(rdv));
  task automatic stop_test;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge clk) rst_n <= 1'h0;
    // Held past three pixel-clock edges so the pixel side sees it too
    repeat (32) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk) #1;
    mem.log_a.delete();
    mem.log_d.delete();
    `CHK({iovf, oovf, av}, 3'h0)
    repeat (4) @(posedge pclk);
  endtask
  function automatic logic [23:0] pval(int s, int k);
    return 24'(s * 65536 + k);
  endfunction
  task automatic pix(input logic v, vs, f, input logic [23:0] d);
    @(posedge pclk);
    pv <= v;
    pvs <= vs;
    pf <= f;
    prgb <= d;
  endtask
  task automatic send_field(input logic f, input int n, s);
    pix(1'h1, 1'h0, f, ~pval(s, 0));
    for (int k = 0; k < 4 * n; k++) begin
      if (k % 7 == 3)
        pix(1'h0, 1'h1, f, ~pval(s, k));
      pix(1'h1, k == 0, (k == 0) ? f : ~f, pval(s, k));
    end
    pix(1'h0, 1'h0, f, ~pval(s, 4 * n - 1));
  endtask
  task automatic check_burst(input logic f, input int n, s);
    logic [23:0]  base;
    logic [127:0] w;
    int           t;
    base = (f ^ `DVP_FIELD_POLARITY) ? `DVP_START_ADDR1 : `DVP_START_ADDR0;
    t = 0;
    while (mem.log_a.size() < n && t < 4000) begin
      @(posedge clk);
      t++;
    end
    `CHK(mem.log_a.size(), n)
    for (int i = 0; i < n && i < mem.log_a.size(); i++) begin
      w = '0;
      for (int j = 0; j < 4; j++)
        w[32 * j +: 24] = pval(s, 4 * i + j);
      `CHK(mem.log_a[i], base + 24'(i))
      `CHK(mem.log_d[i], w)
    end
    mem.log_a.delete();
    mem.log_d.delete();
  endtask
  task automatic t_fields;
    @(posedge clk) mm <= 2'h2;
    send_field(1'h0, 32, 1);
    repeat (20) @(posedge clk);
    #1;
    `CHK({av, iovf}, 2'h2)
    `CHK(mem.log_a.size(), 0)
    @(posedge clk) mm <= 2'h0;
    check_burst(1'h0, 32, 1);
    @(posedge clk) mm <= 2'h1;
    send_field(1'h1, 16, 2);
    check_burst(1'h1, 16, 2);
  endtask
  task automatic t_ovf_out;
    @(posedge clk) spray <= 1'h1;
    // Sprayed words also reach the pixel stage: first pixel opens a frame
    do begin
      @(posedge clk);
      #1;
    end while (!pixo_v);
    `CHK({pixo.frame_sync, pixo.line_sync}, 2'h3)
    while (!prdy) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk) #1;
    `CHK({pixo_v, pixo.frame_sync, pixo.line_sync}, 3'h4)
    repeat (300) @(posedge clk);
    spray <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK({oovf, iovf}, 2'h2)
    do_reset();
  endtask
  task automatic t_ovf_in;
    @(posedge clk) mm <= 2'h2;
    send_field(1'h0, 48, 3);
    repeat (10) @(posedge clk);
    #1;
    `CHK({iovf, oovf}, 2'h2)
    do_reset();
    @(posedge clk) mm <= 2'h0;
    send_field(1'h1, 16, 4);
    check_burst(1'h1, 16, 4);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial begin
    do_reset();
    t_fields();
    t_ovf_out();
    t_ovf_in();
    stop_test();
  end
endmodule
`default_nettype wire

// ### inc/dvp_consts.svh
`ifndef DVP_CONSTS_SVH
`define DVP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Data path widths
// ----------------------------------------------------------------------------
`define DVP_DATA_W           128
`define DVP_PIX_W            24
`define DVP_LANE_W           32
`define DVP_PIX_PER_WORD     4
`define DVP_ADDR_W           24

// ----------------------------------------------------------------------------
// Frame geometry and memory layout
// ----------------------------------------------------------------------------
`define DVP_BURST            16
`define DVP_LINE_WIDTH       1024
`define DVP_LINES_PER_FIELD  288
`define DVP_WORDS_PER_LINE   (`DVP_LINE_WIDTH / `DVP_PIX_PER_WORD)
`define DVP_WORDS_PER_FIELD  (`DVP_WORDS_PER_LINE * `DVP_LINES_PER_FIELD)
`define DVP_START_ADDR0      24'h000000
`define DVP_START_ADDR1      24'h020000
`define DVP_FIELD_POLARITY   1'b0

// ----------------------------------------------------------------------------
// Buffer depths and timing
// ----------------------------------------------------------------------------
`define DVP_IN_AW            5
`define DVP_OUT_AW           8
`define DVP_RD_LATENCY_MAX   256

`endif

// ### inc/dvp_pkg.sv
`include "dvp_consts.svh"

package dvp_pkg;

  // Gray along IDLE -> WRITE -> IDLE and IDLE -> READ -> IDLE
  typedef enum logic [1:0] {
    DVP_IDLE  = 2'b00,
    DVP_WRITE = 2'b01,
    DVP_READ  = 2'b10
  } dvp_state_t;

  typedef struct packed {
    logic                      field;
    logic                      sof;
    logic [`DVP_DATA_W-1:0]    data;
  } dvp_in_word_t;

  typedef struct packed {
    logic                      frame_sync;
    logic                      line_sync;
    logic [`DVP_PIX_W-1:0]     rgb;
  } dvp_pixel_t;

endpackage

// ### rtl/dvp_ram.sv
`timescale 1ns/1ps
`default_nettype none

module dvp_ram #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  input  wire logic          wr_clk_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [W-1:0]  wr_data_in,
  input  wire logic          rd_clk_in,
  input  wire logic          rd_en_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [W-1:0]  rd_data_out
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge wr_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read; no reset so it maps onto block memory
  always_ff @(posedge rd_clk_in) begin
    if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule

`default_nettype wire

// ### rtl/dvp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dvp_consts.svh"

// Overview of operation
// - Input pixels presented while the input qualifier is low are discarded.
// - The field flag is the odd/even identifier, sampled only with field-start and qualifier high.
// - A build-time polarity setting inverts the meaning of the field flag.
// - An output pixel with its syncs moves on a rising clock edge only when valid and ready are high.
// - While the sink holds ready low the output stalls and input keeps going to the frame buffer.
// - Frame sync and line sync are both high with the first pixel of each output frame.
// - Every other output line starts with line sync high and frame sync low on its first pixel.
// - The memory data path is 128 bits wide with one word per address.
// - Each write burst is a block of exactly the configured burst-size number of words.
// - Word addresses inside one burst are strictly sequential.
// - Address-valid drops for at least one cycle between consecutive bursts, longer while no burst is pending.
// - Input FIFO overflow raises the input overflow error flag.
// - Output FIFO overflow raises the output overflow error flag.
// - After an overflow only a reset recovers, after which input resyncs to the next field start.
module dvp_top (
  input  wire logic                   clock_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   clk_en_in,
  input  wire logic                   pix_clk_in,
  input  wire logic                   pix_val_in,
  input  wire logic                   pix_vsync_in,
  input  wire logic                   pix_field_in,
  input  wire logic [`DVP_PIX_W-1:0]  pix_rgb_in,
  output dvp_pkg::dvp_pixel_t         pixout_out,
  output logic                        pixout_valid_out,
  input  wire logic                   pixout_rdy_in,
  output logic [`DVP_ADDR_W-1:0]      mem_addr_out,
  output logic                        mem_addr_valid_out,
  output logic                        mem_wr_out,
  output logic [`DVP_DATA_W-1:0]      mem_wdata_out,
  input  wire logic                   mem_addr_rdy_in,
  input  wire logic [`DVP_DATA_W-1:0] mem_rdata_in,
  input  wire logic                   mem_rdata_valid_in,
  output logic                        input_overflow_error_out,
  output logic                        output_overflow_error_out
);

  // --------------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------------
  localparam int IAW   = `DVP_IN_AW;
  localparam int IPW   = IAW + 1;
  localparam int OAW   = `DVP_OUT_AW;
  localparam int OPW   = OAW + 1;
  localparam int IWW   = `DVP_DATA_W + 2;
  localparam int LPF2  = 2 * `DVP_LINES_PER_FIELD;
  localparam int YW    = $clog2(LPF2);
  localparam int XW    = $clog2(`DVP_LINE_WIDTH);
  localparam int WLW   = $clog2(`DVP_WORDS_PER_LINE);
  localparam int WFW   = $clog2(`DVP_WORDS_PER_FIELD);
  localparam int BW    = $clog2(`DVP_BURST);
  localparam int AW    = `DVP_ADDR_W;

  localparam logic [IPW-1:0] IN_DEPTH  = IPW'(1 << IAW);
  localparam logic [IPW-1:0] IN_BURST  = IPW'(`DVP_BURST);
  localparam logic [OPW-1:0] OUT_DEPTH = OPW'(1 << OAW);
  localparam logic [OPW-1:0] OUT_BURST = OPW'(`DVP_BURST);
  localparam logic [BW-1:0]  LAST_BEAT = BW'(`DVP_BURST - 1);
  localparam logic [WFW-1:0] LAST_FW   = WFW'(`DVP_WORDS_PER_FIELD - 1);
  localparam logic [WLW-1:0] LAST_LBRS = WLW'(`DVP_WORDS_PER_LINE - `DVP_BURST);
  localparam logic [WLW-1:0] WL_BURST  = WLW'(`DVP_BURST);
  localparam logic [YW-1:0]  LAST_Y    = YW'(LPF2 - 1);
  localparam logic [XW-1:0]  LAST_X    = XW'(`DVP_LINE_WIDTH - 1);
  localparam logic [AW-1:0]  WPL_A     = AW'(`DVP_WORDS_PER_LINE);

  function automatic logic [IPW-1:0] bin2gray(input logic [IPW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [IPW-1:0] gray2bin(input logic [IPW-1:0] g);
    logic [IPW-1:0] b;
    b[IPW-1] = g[IPW-1];
    for (int i = IPW - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    gray2bin = b;
  endfunction

  // --------------------------------------------------------------------------
  // Pixel clock domain: reset, enable, packing into 128-bit words
  // --------------------------------------------------------------------------
  logic                 prst_s1_q;
  logic                 prst_s2_q;
  logic                 pce_s1_q;
  logic                 pce_s2_q;
  logic [1:0]           slot_q;
  logic [1:0]           slot_now;
  logic [`DVP_DATA_W-1:0] word_q;
  logic                 sof_q;
  logic                 fld_q;
  logic                 armed_q;
  logic                 push_q;
  logic                 take;
  logic                 in_full;
  logic                 in_wr;
  logic                 in_ovf_q;
  logic [IPW-1:0]       wbin_q;
  logic [IPW-1:0]       wgray_q;
  logic [IPW-1:0]       rg_s1_q;
  logic [IPW-1:0]       rg_s2_q;
  logic [IPW-1:0]       rgray_q;
  dvp_pkg::dvp_in_word_t in_wdata;

  // Reset and enable come from the system domain and are resynchronised here
  always_ff @(posedge pix_clk_in) begin
    prst_s1_q <= rst_n_in;
    prst_s2_q <= prst_s1_q;
    pce_s1_q  <= clk_en_in;
    pce_s2_q  <= pce_s1_q;
  end

  assign slot_now = pix_vsync_in ? 2'h0 : slot_q;
  // Pixels before the first field start are dropped so packing lines up
  assign take     = pix_val_in && (pix_vsync_in || armed_q);

  always_ff @(posedge pix_clk_in) begin
    if (!prst_s2_q) begin
      slot_q  <= 2'h0;
      word_q  <= '0;
      sof_q   <= 1'b0;
      fld_q   <= 1'b0;
      armed_q <= 1'b0;
      push_q  <= 1'b0;
    end else if (pce_s2_q) begin
      push_q <= take && (slot_now == 2'h3);
      if (push_q) begin
        sof_q <= 1'b0;
      end
      if (take) begin
        word_q[{slot_now, 5'h00} +: `DVP_LANE_W] <= {8'h00, pix_rgb_in};
        slot_q <= slot_now + 2'h1;
      end
      if (pix_val_in && pix_vsync_in) begin
        fld_q   <= pix_field_in ^ `DVP_FIELD_POLARITY;
        sof_q   <= 1'b1;
        armed_q <= 1'b1;
      end
    end
  end

  assign in_full  = IPW'(wbin_q - gray2bin(rg_s2_q)) == IN_DEPTH;
  assign in_wr    = push_q && !in_full && pce_s2_q;
  assign in_wdata = '{field: fld_q, sof: sof_q, data: word_q};

  always_ff @(posedge pix_clk_in) begin
    if (!prst_s2_q) begin
      wbin_q   <= '0;
      wgray_q  <= '0;
      rg_s1_q  <= '0;
      rg_s2_q  <= '0;
      in_ovf_q <= 1'b0;
    end else if (pce_s2_q) begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
      if (in_wr) begin
        wbin_q  <= wbin_q + IPW'(1);
        wgray_q <= bin2gray(wbin_q + IPW'(1));
      end
      // Sticky until reset; the word is lost
      if (push_q && in_full) begin
        in_ovf_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Crossing FIFO, read side on the system clock
  // --------------------------------------------------------------------------
  logic [IPW-1:0]        rbin_q;
  logic [IPW-1:0]        rbin_nx;
  logic [IPW-1:0]        wg_s1_q;
  logic [IPW-1:0]        wg_s2_q;
  logic [IPW-1:0]        in_count;
  logic                  in_pop;
  logic                  ovf_s1_q;
  logic                  input_overflow_error_q;
  dvp_pkg::dvp_in_word_t in_head;

  assign rbin_nx  = rbin_q + IPW'(in_pop);
  assign in_count = IPW'(gray2bin(wg_s2_q) - rbin_q);

  dvp_ram #(.W(IWW), .AW(IAW)) u_in_ram (
    .wr_clk_in   (pix_clk_in),
    .wr_en_in    (in_wr),
    .wr_addr_in  (wbin_q[IAW-1:0]),
    .wr_data_in  (in_wdata),
    .rd_clk_in   (clock_in),
    .rd_en_in    (clk_en_in),
    .rd_addr_in  (rbin_nx[IAW-1:0]),
    .rd_data_out (in_head)
  );

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rbin_q                 <= '0;
      rgray_q                <= '0;
      wg_s1_q                <= '0;
      wg_s2_q                <= '0;
      ovf_s1_q               <= 1'b0;
      input_overflow_error_q <= 1'b0;
    end else if (clk_en_in) begin
      wg_s1_q                <= wgray_q;
      wg_s2_q                <= wg_s1_q;
      ovf_s1_q               <= in_ovf_q;
      input_overflow_error_q <= ovf_s1_q;
      rbin_q                 <= rbin_nx;
      rgray_q                <= bin2gray(rbin_nx);
    end
  end

  // --------------------------------------------------------------------------
  // Memory burst sequencer
  // --------------------------------------------------------------------------
  dvp_pkg::dvp_state_t     st_q;
  logic [AW-1:0]           mem_addr_q;
  logic                    mem_addr_valid_q;
  logic                    mem_wr_q;
  logic [`DVP_DATA_W-1:0]  mem_wdata_q;
  logic [BW-1:0]           beat_q;
  logic [WFW-1:0]          wcnt_q;
  logic                    wfield_q;
  logic [1:0]              seen_q;
  logic [YW-1:0]           rd_line_q;
  logic [WLW-1:0]          rd_word_q;
  logic [OPW-1:0]          out_used_q;
  logic                    hs;
  logic                    start_wr;
  logic                    start_rd;
  logic                    last_beat;
  logic                    out_pop;
  logic [AW-1:0]           rd_addr_c;
  logic [AW-1:0]           wr_base_c;

  assign hs        = mem_addr_valid_q && mem_addr_rdy_in;
  assign last_beat = beat_q == LAST_BEAT;
  assign start_wr  = (st_q == dvp_pkg::DVP_IDLE) && (in_count >= IN_BURST);
  // Reads only go out when the output FIFO can take the whole burst
  assign start_rd  = (st_q == dvp_pkg::DVP_IDLE) && !start_wr && (&seen_q) &&
                     (out_used_q <= OUT_DEPTH - OUT_BURST);
  assign in_pop    = start_wr || ((st_q == dvp_pkg::DVP_WRITE) && hs && !last_beat);
  assign wr_base_c = in_head.sof ?
                     (in_head.field ? `DVP_START_ADDR1 : `DVP_START_ADDR0) :
                     ((wfield_q ? `DVP_START_ADDR1 : `DVP_START_ADDR0) + AW'(wcnt_q));
  assign rd_addr_c = (rd_line_q[0] ? `DVP_START_ADDR1 : `DVP_START_ADDR0) +
                     AW'(rd_line_q[YW-1:1]) * WPL_A + AW'(rd_word_q);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st_q             <= dvp_pkg::DVP_IDLE;
      mem_addr_q       <= '0;
      mem_addr_valid_q <= 1'b0;
      mem_wr_q         <= 1'b0;
      mem_wdata_q      <= '0;
      beat_q           <= '0;
    end else if (clk_en_in) begin
      case (st_q)
        dvp_pkg::DVP_IDLE: begin
          // Valid is low for at least this one cycle between bursts
          beat_q <= '0;
          if (start_wr) begin
            st_q             <= dvp_pkg::DVP_WRITE;
            mem_addr_q       <= wr_base_c;
            mem_wdata_q      <= in_head.data;
            mem_addr_valid_q <= 1'b1;
            mem_wr_q         <= 1'b1;
          end else if (start_rd) begin
            st_q             <= dvp_pkg::DVP_READ;
            mem_addr_q       <= rd_addr_c;
            mem_addr_valid_q <= 1'b1;
            mem_wr_q         <= 1'b0;
          end
        end
        dvp_pkg::DVP_WRITE,
        dvp_pkg::DVP_READ: begin
          if (hs) begin
            if (last_beat) begin
              st_q             <= dvp_pkg::DVP_IDLE;
              mem_addr_valid_q <= 1'b0;
            end else begin
              beat_q      <= beat_q + BW'(1);
              mem_addr_q  <= mem_addr_q + AW'(1);
              mem_wdata_q <= in_head.data;
            end
          end
        end
        default: begin
          st_q             <= dvp_pkg::DVP_IDLE;
          mem_addr_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // Field bookkeeping: output starts once both fields have been stored once
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wcnt_q   <= '0;
      wfield_q <= 1'b0;
      seen_q   <= 2'h0;
    end else if (clk_en_in) begin
      if (start_wr && in_head.sof) begin
        wcnt_q   <= '0;
        wfield_q <= in_head.field;
      end else if ((st_q == dvp_pkg::DVP_WRITE) && hs) begin
        if (wcnt_q == LAST_FW) begin
          wcnt_q           <= '0;
          seen_q[wfield_q] <= 1'b1;
        end else begin
          wcnt_q <= wcnt_q + WFW'(1);
        end
      end
    end
  end

  // Read position walks lines alternately from the two fields
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rd_line_q  <= '0;
      rd_word_q  <= '0;
      out_used_q <= '0;
    end else if (clk_en_in) begin
      out_used_q <= out_used_q + (start_rd ? OUT_BURST : OPW'(0)) - OPW'(out_pop);
      if ((st_q == dvp_pkg::DVP_READ) && hs && last_beat) begin
        if (rd_word_q == LAST_LBRS) begin
          rd_word_q <= '0;
          rd_line_q <= (rd_line_q == LAST_Y) ? '0 : rd_line_q + YW'(1);
        end else begin
          rd_word_q <= rd_word_q + WL_BURST;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output FIFO and pixel stage
  // --------------------------------------------------------------------------
  logic [OPW-1:0]         obw_q;
  logic [OPW-1:0]         obw_d1_q;
  logic [OPW-1:0]         obr_q;
  logic [OPW-1:0]         obr_nx;
  logic                   out_full;
  logic                   out_wr;
  logic                   out_empty;
  logic                   ld;
  logic [`DVP_DATA_W-1:0] out_head;
  logic [1:0]             pidx_q;
  logic [XW-1:0]          x_q;
  logic [YW-1:0]          y_q;
  logic                   output_overflow_error_q;
  dvp_pkg::dvp_pixel_t    pixout_q;
  logic                   pixout_valid_q;

  assign out_full  = OPW'(obw_q - obr_q) == OUT_DEPTH;
  assign out_wr    = mem_rdata_valid_in && !out_full && clk_en_in;
  // Delayed write pointer hides the one-cycle read latency of the memory
  assign out_empty = obw_d1_q == obr_q;
  assign ld        = !out_empty && (!pixout_valid_q || pixout_rdy_in);
  assign out_pop   = ld && (pidx_q == 2'h3);
  assign obr_nx    = obr_q + OPW'(out_pop);

  dvp_ram #(.W(`DVP_DATA_W), .AW(OAW)) u_out_ram (
    .wr_clk_in   (clock_in),
    .wr_en_in    (out_wr),
    .wr_addr_in  (obw_q[OAW-1:0]),
    .wr_data_in  (mem_rdata_in),
    .rd_clk_in   (clock_in),
    .rd_en_in    (clk_en_in),
    .rd_addr_in  (obr_nx[OAW-1:0]),
    .rd_data_out (out_head)
  );

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      obw_q                   <= '0;
      obw_d1_q                <= '0;
      obr_q                   <= '0;
      output_overflow_error_q <= 1'b0;
    end else if (clk_en_in) begin
      obw_d1_q <= obw_q;
      obr_q    <= obr_nx;
      if (out_wr) begin
        obw_q <= obw_q + OPW'(1);
      end
      if (mem_rdata_valid_in && out_full) begin
        output_overflow_error_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pixout_q       <= '0;
      pixout_valid_q <= 1'b0;
      pidx_q         <= 2'h0;
      x_q            <= '0;
      y_q            <= '0;
    end else if (clk_en_in) begin
      if (ld) begin
        pixout_q.rgb        <= out_head[{pidx_q, 5'h00} +: `DVP_PIX_W];
        pixout_q.frame_sync <= (x_q == '0) && (y_q == '0);
        pixout_q.line_sync  <= x_q == '0;
        pixout_valid_q      <= 1'b1;
        pidx_q              <= pidx_q + 2'h1;
        if (x_q == LAST_X) begin
          x_q <= '0;
          y_q <= (y_q == LAST_Y) ? '0 : y_q + YW'(1);
        end else begin
          x_q <= x_q + XW'(1);
        end
      end else if (pixout_rdy_in) begin
        pixout_valid_q <= 1'b0;
      end
    end
  end

  assign pixout_out                = pixout_q;
  assign pixout_valid_out          = pixout_valid_q;
  assign mem_addr_out              = mem_addr_q;
  assign mem_addr_valid_out        = mem_addr_valid_q;
  assign mem_wr_out                = mem_wr_q;
  assign mem_wdata_out             = mem_wdata_q;
  assign input_overflow_error_out  = input_overflow_error_q;
  assign output_overflow_error_out = output_overflow_error_q;

endmodule

`default_nettype wire
